/* File: logic/cfu_pkg.sv */
// Purpose: Constants, register map and opcodes of the compare flag unit.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Included by every design file of the compare flag unit except the subtractor.
//
// Behaviour
// - The 16-bit half compare uses pattern 0101 010A LLLL LLLL, bit A picks the half, and it takes one cycle.
// - The 16-bit half compare sets flags on half minus memory word and changes neither.
// - For 16-bit compares the negative flag shows the sign of the exact, unwrapped difference.
// - Every compare sets the zero flag when its difference is zero and clears it otherwise.
// - Subtracting compares clear carry on a borrow and set it when there is none.
// - A compare after a repeat instruction clears the repeat counter and runs only once.
// - The memory-immediate compare subtracts a signed 16-bit constant from the memory word for flags only.
// - The 64-bit zero test uses opcode 0101 0110 0101 1110, takes one cycle and acts only with the object compatibility bit at one.
// - In the 64-bit test the negative flag is accumulator bit 31 exclusive-or overflow.
// - In the 64-bit test the zero flag is set only when all 64 joined bits are zero.
// - Each 64-bit test clears overflow after using it for the sign.
// - The byte compare subtracts the zero-extended low opcode byte from the chosen half in one cycle.
// - The 32-bit compare subtracts a 32-bit memory word from the accumulator in one cycle, changing neither.

package cfu_pkg;

	localparam int ADR_BITS = 5;

	// Word-aligned byte offsets of the register file.
	localparam logic [4:0] OFS_ACC = 5'h00;
	localparam logic [4:0] OFS_PROD = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_MODE = 5'h0c;
	localparam logic [4:0] OFS_REPEAT = 5'h10;

	// Status field positions.
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_N = 2;
	localparam int ST_V = 3;
	localparam int ST_TC = 4;
	localparam int ST_W = 5;

	localparam logic [31:0] ACC_RST = 32'h0000_0000;
	localparam logic [31:0] PROD_RST = 32'h0000_0000;
	localparam logic [4:0] STATUS_RST = 5'h00;
	localparam logic MODE_RST = 1'b0;
	localparam logic [15:0] REPEAT_RST = 16'h0000;

	// Opcode fields.
	localparam logic [6:0] OPC_CMP16 = 7'h2a;
	localparam logic [6:0] OPC_COMPARE_BYTE_IMM = 7'h29;
	localparam logic [7:0] OPC_CMP32 = 8'h0f;
	localparam logic [15:0] OPC_TEST64 = 16'h565e;
	localparam logic [15:0] OPC_MEMIMM = 16'h0008;
	localparam int HALF_BIT = 8;

	function automatic logic [31:0] cfu_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

/* File: logic/cfu_subtract.sv */
// Purpose: Flag-only subtractor with exact sign, zero and no-borrow.
// Assumes: Operands are two's complement for the sign, unsigned for carry.
// Notes: The extra top bit keeps the sign correct when W bits would wrap.
`timescale 1ns/1ns

module cfu_subtract #(
	parameter int W = 16
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	output logic neg,
	output logic zero,
	output logic carry
);
	if (W < 2)
	begin : g_chk
		$error("cfu_subtract needs W of at least 2");
	end

	logic [W:0] sdiff;
	logic [W:0] udiff;

	assign sdiff = {a[W-1], a} - {b[W-1], b};
	assign udiff = {1'b0, a} - {1'b0, b};
	assign neg = sdiff[W];
	assign zero = (sdiff[W-1:0] == '0);
	assign carry = ~udiff[W];

endmodule // cfu_subtract

/* File: logic/cfu_wb_slave.sv */
// Purpose: Classic Wishbone decode, acknowledge and read-back mux.
// Assumes: Single classic cycles; the master holds the request until ack.
// Notes: Unmapped offsets acknowledge, read zero and ignore writes.
`timescale 1ns/1ns

module cfu_wb_slave
	import cfu_pkg::*;
#(
	parameter int ADR_W = 5
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] acc_v,
	input wire logic [31:0] prod_v,
	input wire logic [ST_W-1:0] stat_v,
	input wire logic mode_v,
	input wire logic [15:0] rpt_v,
	output logic wr_acc,
	output logic wr_prod,
	output logic wr_stat,
	output logic wr_mode,
	output logic wr_rpt,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o
);
	logic ack_q;
	logic [31:0] dat_q;
	wire take = wb_cyc_i & wb_stb_i & ~ack_q;
	wire [4:0] ofs = {wb_adr_i[4:2], 2'b00};
	// Only address bits above the five offset bits must be clear; bit 4
	// itself selects the repeat counter and must not be masked.
	wire hi_zero = ((wb_adr_i >> 5) == '0);
	wire hit_acc = hi_zero & (ofs == OFS_ACC);
	wire hit_prod = hi_zero & (ofs == OFS_PROD);
	wire hit_stat = hi_zero & (ofs == OFS_STATUS);
	wire hit_mode = hi_zero & (ofs == OFS_MODE);
	wire hit_rpt = hi_zero & (ofs == OFS_REPEAT);
	wire [31:0] rd_mux =
		hit_acc ? acc_v :
		hit_prod ? prod_v :
		hit_stat ? {27'h000_0000, stat_v} :
		hit_mode ? {31'h0000_0000, mode_v} :
		hit_rpt ? {16'h0000, rpt_v} : 32'h0000_0000;

	assign wr_acc = take & wb_we_i & hit_acc;
	assign wr_prod = take & wb_we_i & hit_prod;
	assign wr_stat = take & wb_we_i & hit_stat;
	assign wr_mode = take & wb_we_i & hit_mode;
	assign wr_rpt = take & wb_we_i & hit_rpt;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= take;
			dat_q <= take ? rd_mux : 32'h0000_0000;
		end
	end

endmodule // cfu_wb_slave

/* File: logic/cfu_compare_flag_unit.sv */
// Purpose: Compare datapath that sets N, Z, C and V from decoded compares.
// Assumes: instr_valid is a one-cycle strobe with opcode and operands.
// Notes: Operands are never written back; only status and the repeat counter change.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns

module cfu_compare_flag_unit
	import cfu_pkg::*;
#(
	parameter int ADR_W = 5
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic instr_valid,
	input wire logic [15:0] instr_opcode,
	input wire logic [15:0] instr_imm16,
	input wire logic [15:0] operand16_location,
	input wire logic [31:0] operand32_location,
	output logic [ST_W-1:0] status_o,
	output logic object_compat_bit,
	output logic [15:0] repeat_counter,
	output logic done_o,
	output logic illegal_o
);
	if (ADR_W < ADR_BITS)
	begin : g_chk
		$error("cfu_compare_flag_unit needs ADR_W of at least 5");
	end

	logic [31:0] acc_q;
	logic [31:0] prod_q;
	logic [ST_W-1:0] stat_q;
	logic [ST_W-1:0] stat_d;
	logic mode_q;
	logic [15:0] rpt_q;
	logic done_q;
	logic illegal_q;
	logic wr_acc;
	logic wr_prod;
	logic wr_stat;
	logic wr_mode;
	logic wr_rpt;
	logic n16;
	logic z16;
	logic c16;
	logic n32;
	logic z32;
	logic c32;

	// Instruction decode.
	wire is16 = instr_valid & (instr_opcode[15:9] == OPC_CMP16);
	wire isb = instr_valid & (instr_opcode[15:9] == OPC_COMPARE_BYTE_IMM);
	wire is32 = instr_valid & (instr_opcode[15:8] == OPC_CMP32);
	wire ismi = instr_valid & (instr_opcode == OPC_MEMIMM);
	wire hit64 = instr_valid & (instr_opcode == OPC_TEST64);
	wire is64 = hit64 & mode_q;
	wire bad64 = hit64 & ~mode_q;
	wire use16 = is16 | isb | ismi;
	wire exec = use16 | is32 | is64;

	// Operand selection; the chosen half is read, never written.
	wire [15:0] upper_half_reg = acc_q[31:16];
	wire [15:0] lower_half_reg = acc_q[15:0];
	wire [15:0] chosen_half =
		instr_opcode[HALF_BIT] ? upper_half_reg : lower_half_reg;
	wire [15:0] byte_imm = {8'h00, instr_opcode[7:0]};
	wire [15:0] a16 = ismi ? operand16_location : chosen_half;
	wire [15:0] b16 =
		ismi ? instr_imm16 :
		isb ? byte_imm : operand16_location;
	wire [63:0] joined_64_value = {acc_q, prod_q};
	wire neg64 = acc_q[31] ^ stat_q[ST_V];
	wire zero64 = (joined_64_value == 64'h0000_0000_0000_0000);

	cfu_subtract #(
		.W(16)
	) u_sub16 (
		.a(a16),
		.b(b16),
		.neg(n16),
		.zero(z16),
		.carry(c16)
	);

	cfu_subtract #(
		.W(32)
	) u_sub32 (
		.a(acc_q),
		.b(operand32_location),
		.neg(n32),
		.zero(z32),
		.carry(c32)
	);

	cfu_wb_slave #(
		.ADR_W(ADR_W)
	) u_wb (
		.clk(clk),
		.reset(reset),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.acc_v(acc_q),
		.prod_v(prod_q),
		.stat_v(stat_q),
		.mode_v(mode_q),
		.rpt_v(rpt_q),
		.wr_acc(wr_acc),
		.wr_prod(wr_prod),
		.wr_stat(wr_stat),
		.wr_mode(wr_mode),
		.wr_rpt(wr_rpt),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o)
	);

	wire [31:0] stat_wr = cfu_merge({27'h000_0000, stat_q}, wb_dat_i,
		wb_sel_i);

	// Flag update. A compare in the same cycle as a software write to
	// status wins for the bits it names, so no hardware result is lost.
	always_comb
	begin
		stat_d = stat_q;
		if (wr_stat)
		begin
			stat_d = stat_wr[ST_W-1:0];
		end
		if (use16)
		begin
			stat_d[ST_N] = n16;
			stat_d[ST_Z] = z16;
			stat_d[ST_C] = c16;
		end
		else if (is32)
		begin
			stat_d[ST_N] = n32;
			stat_d[ST_Z] = z32;
			stat_d[ST_C] = c32;
		end
		else if (is64)
		begin
			stat_d[ST_N] = neg64;
			stat_d[ST_Z] = zero64;
			stat_d[ST_V] = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stat_q <= STATUS_RST;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			done_q <= exec;
			illegal_q <= bad64;
		end
	end

	// Accumulator and product change only by software writes.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc_q <= ACC_RST;
			prod_q <= PROD_RST;
			mode_q <= MODE_RST;
		end
		else
		begin
			if (wr_acc)
			begin
				acc_q <= cfu_merge(acc_q, wb_dat_i, wb_sel_i);
			end
			if (wr_prod)
			begin
				prod_q <= cfu_merge(prod_q, wb_dat_i, wb_sel_i);
			end
			if (wr_mode & wb_sel_i[0])
			begin
				mode_q <= wb_dat_i[0];
			end
		end
	end

	// A compare is never repeated: it runs once and empties the counter.
	wire [31:0] rpt_wr = cfu_merge({16'h0000, rpt_q}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rpt_q <= REPEAT_RST;
		end
		else if (exec)
		begin
			rpt_q <= REPEAT_RST;
		end
		else if (wr_rpt)
		begin
			rpt_q <= rpt_wr[15:0];
		end
	end

	assign status_o = stat_q;
	assign object_compat_bit = mode_q;
	assign repeat_counter = rpt_q;
	assign done_o = done_q;
	assign illegal_o = illegal_q;

	// Checking helpers, computed independently of the subtractors.
	wire lt16 = ($signed(a16) < $signed(b16));
	wire ge16 = (a16 >= b16);
	wire lt32 = ($signed(acc_q) < $signed(operand32_location));
	wire ge32 = (acc_q >= operand32_location);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_exec;
		exec;
	endsequence

	sequence s_once;
		done_q && (rpt_q == REPEAT_RST) ##1 !done_q || exec;
	endsequence

	repeat_once_a: assert property (s_exec |=> s_once)
		else $error("compare did not run once or kept repeat count");

	// Flags are judged one cycle after the compare, once status has settled.
	one_cycle_a: assert property (exec |=> done_o)
		else $error("compare did not finish in one cycle");

	cmp16_sign_a: assert property (use16 |=>
		stat_q[ST_N] == $past(lt16))
		else $error("16-bit compare sign is not the exact sign");

	cmp16_carry_a: assert property (use16 |=>
		stat_q[ST_C] == $past(ge16))
		else $error("16-bit compare carry does not match borrow");

	cmp16_zero_a: assert property (is16 |=>
		stat_q[ST_Z] == ($past(chosen_half) == $past(operand16_location)))
		else $error("16-bit compare zero flag wrong");

	byte_zero_a: assert property (isb |=>
		stat_q[ST_Z] == ($past(chosen_half) == $past(byte_imm)))
		else $error("byte compare zero flag wrong");

	memimm_zero_a: assert property (ismi |=>
		stat_q[ST_Z] == ($past(operand16_location) == $past(instr_imm16)))
		else $error("memory immediate compare zero flag wrong");

	cmp32_flags_a: assert property (is32 |=>
		stat_q[ST_N] == $past(lt32) && stat_q[ST_C] == $past(ge32))
		else $error("32-bit compare sign or carry wrong");

	cmp32_zero_a: assert property (is32 |=>
		stat_q[ST_Z] == ($past(acc_q) == $past(operand32_location)))
		else $error("32-bit compare zero flag wrong");

	acc_kept_a: assert property (exec && !wr_acc |=>
		$stable(acc_q))
		else $error("compare changed the accumulator");

	test64_sign_a: assert property (is64 |=>
		stat_q[ST_N] == ($past(acc_q[31]) ^ $past(stat_q[ST_V])))
		else $error("64-bit test sign wrong");

	test64_zero_a: assert property (is64 |=>
		stat_q[ST_Z] == ($past(acc_q) == 32'h0000_0000 &&
		$past(prod_q) == 32'h0000_0000))
		else $error("64-bit test zero flag wrong");

	test64_keep_a: assert property (is64 && !wr_stat |=>
		$stable(stat_q[ST_C]) && $stable(stat_q[ST_TC]))
		else $error("64-bit test disturbed carry or test-control");

	rpt_kept_a: assert property (bad64 && !wr_rpt |=>
		$stable(rpt_q))
		else $error("refused 64-bit test changed the repeat counter");

	test64_vclr_a: assert property (is64 |=> !stat_q[ST_V])
		else $error("64-bit test left overflow set");

	obj_gate_a: assert property (bad64 && !wr_stat |=>
		$stable(stat_q) ##0 illegal_o)
		else $error("64-bit test acted with the compat bit clear");

	other_kept_a: assert property ((use16 || is32) && !wr_stat
		|=> $stable(stat_q[ST_V]) && $stable(stat_q[ST_TC]))
		else $error("compare disturbed overflow or test-control");

endmodule // cfu_compare_flag_unit

/* File: verification/cfu_fetch_model.sv */
// Purpose: Fetch-side model that hands one decoded compare to the unit.
// Assumes: The bench raises req for exactly one clock.
// Notes: Idle operand lines toggle, so a stale value is never trusted.
`timescale 1ns/1ns

module cfu_fetch_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [15:0] op,
	input wire logic [15:0] imm,
	input wire logic [15:0] m16,
	input wire logic [31:0] m32,
	output logic instr_valid = 1'b0,
	output logic [15:0] instr_opcode = 16'h0000,
	output logic [15:0] instr_imm16 = 16'h0000,
	output logic [15:0] operand16_location = 16'h0000,
	output logic [31:0] operand32_location = 32'h0000_0000
);
	always @(posedge clk)
	begin
		instr_valid <= req;
		instr_opcode <= req ? op : ~instr_opcode;
		instr_imm16 <= req ? imm : ~instr_imm16;
		operand16_location <= req ? m16 : ~operand16_location;
		operand32_location <= req ? m32 : ~operand32_location;
	end
endmodule // cfu_fetch_model

/* File: verification/tb_compare_flag_unit.sv */
// Purpose: Self-checking bench of the compare flag unit.
// Assumes: Wishbone ack comes one cycle after a taken request.
// Notes: Expected flags are computed here from exact signed arithmetic.
`timescale 1ns/1ns

module tb_compare_flag_unit
	import cfu_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic req = 1'b0;
	logic [15:0] op = 16'h0000;
	logic [15:0] imm = 16'h0000;
	logic [15:0] m16 = 16'h0000;
	logic [31:0] m32 = 32'h0000_0000;
	logic ack, iv, cb, done, ill, ldone, lill;
	logic [31:0] rdat, i32, rd;
	logic [15:0] iop, iimm, i16, rc;
	logic [ST_W-1:0] st, es;
	int n_mismatch = 0;
	int checked = 0;

	always #5 clk = ~clk;

	cfu_fetch_model fm (.clk(clk), .req(req), .op(op), .imm(imm), .m16(m16),
		.m32(m32), .instr_valid(iv), .instr_opcode(iop),
		.instr_imm16(iimm), .operand16_location(i16),
		.operand32_location(i32));

	cfu_compare_flag_unit #(.ADR_W(ADR_BITS)) dut (.clk(clk), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.instr_valid(iv), .instr_opcode(iop), .instr_imm16(iimm),
		.operand16_location(i16), .operand32_location(i32), .status_o(st),
		.object_compat_bit(cb), .repeat_counter(rc), .done_o(done),
		.illegal_o(ill));

	// Sign comes from unbounded arithmetic, so wrapped results cannot fool it.
	function automatic logic [4:0] fl(input logic [31:0] a,
		input logic [31:0] b, input bit h, input logic [4:0] o);
		longint sa, sb;
		sa = h ? longint'($signed(a[15:0])) : longint'($signed(a));
		sb = h ? longint'($signed(b[15:0])) : longint'($signed(b));
		return {o[4:3], sa < sb, sa == sb, h ? a[15:0] >= b[15:0] : a >= b};
	endfunction

	task tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task hang();
		n_mismatch++;
		tally_and_finish();
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task cst();
		chk(32'(st), 32'(es));
	endtask

	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		if (i == 20)
			hang();
	endtask

	task rdchk(input logic [4:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	task ex(input logic [15:0] o, input logic [15:0] i, input logic [15:0] a,
		input logic [31:0] b);
		int k;
		@(posedge clk);
		req <= 1'b1;
		op <= o;
		imm <= i;
		m16 <= a;
		m32 <= b;
		@(posedge clk);
		req <= 1'b0;
		for (k = 0; k < 20; k++)
		begin
			@(posedge clk);
			if (done === 1'b1 || ill === 1'b1)
				break;
		end
		ldone = done;
		lill = ill;
		if (k == 20)
			hang();
	endtask

	task t_reset();
		cst_zero();
		rdchk(OFS_MODE, 32'h0000_0000);
		rdchk(OFS_REPEAT, 32'h0000_0000);
		wb(1'b1, 5'h14, 32'hffff_ffff);
		rdchk(5'h14, 32'h0000_0000);
		$display("t_reset done");
	endtask

	task cst_zero();
		es = 5'h00;
		cst();
		rdchk(OFS_STATUS, 32'h0000_0000);
	endtask

	task t_cmp();
		wb(1'b1, OFS_STATUS, 32'h0000_0018);
		wb(1'b1, OFS_ACC, 32'h8000_0003);
		es = 5'h18;
		ex({OPC_CMP16, 1'b1, 8'h12}, 16'h0000, 16'h0001, 32'h0000_0000);
		es = fl(16'h8000, 16'h0001, 1'b1, es);
		cst();
		ex({OPC_CMP16, 1'b0, 8'h34}, 16'h0000, 16'h0003, 32'h0000_0000);
		es = fl(16'h0003, 16'h0003, 1'b1, es);
		cst();
		ex({OPC_COMPARE_BYTE_IMM, 1'b0, 8'hf0}, 16'h0000, 16'h0003, 32'h0000_0000);
		es = fl(16'h0003, 16'h00f0, 1'b1, es);
		cst();
		ex({OPC_COMPARE_BYTE_IMM, 1'b1, 8'h80}, 16'h0000, 16'h8000, 32'h0000_0000);
		es = fl(16'h8000, 16'h0080, 1'b1, es);
		cst();
		ex(OPC_MEMIMM, 16'hffff, 16'h0005, 32'h0000_0000);
		es = fl(16'h0005, 16'hffff, 1'b1, es);
		cst();
		ex({OPC_CMP32, 8'h56}, 16'h0000, 16'h0000, 32'h0000_0004);
		es = fl(32'h8000_0003, 32'h0000_0004, 1'b0, es);
		cst();
		rdchk(OFS_ACC, 32'h8000_0003);
		rdchk(OFS_STATUS, 32'(es));
		$display("t_cmp done");
	endtask

	task t_rpt();
		wb(1'b1, OFS_REPEAT, 32'h0000_0005);
		ex({OPC_CMP16, 1'b0, 8'h00}, 16'h0000, 16'h0003, 32'h0000_0000);
		chk(32'(rc), 32'h0000_0000);
		chk(32'(ldone), 32'h0000_0001);
		rdchk(OFS_REPEAT, 32'h0000_0000);
		$display("t_rpt done");
	endtask

	task t_64();
		wb(1'b1, OFS_STATUS, 32'h0000_000b);
		wb(1'b1, OFS_REPEAT, 32'h0000_0003);
		es = 5'h0b;
		ex(OPC_TEST64, 16'h0000, 16'h0000, 32'h0000_0000);
		cst();
		chk(32'(lill), 32'h0000_0001);
		chk(32'(rc), 32'h0000_0003);
		wb(1'b1, OFS_MODE, 32'h0000_0001);
		chk(32'(cb), 32'h0000_0001);
		wb(1'b1, OFS_ACC, 32'h0000_0001);
		wb(1'b1, OFS_PROD, 32'h0000_0000);
		wb(1'b1, OFS_STATUS, 32'h0000_0019);
		// A leading test clears V before a 64-bit sequence.
		ex(OPC_TEST64, 16'h0000, 16'h0000, 32'h0000_0000);
		es = 5'h15;
		cst();
		chk(32'(rc), 32'h0000_0000);
		wb(1'b1, OFS_ACC, 32'h0000_0000);
		ex(OPC_TEST64, 16'h0000, 16'h0000, 32'h0000_0000);
		es = 5'h13;
		cst();
		wb(1'b1, OFS_PROD, 32'h0000_0001);
		ex(OPC_TEST64, 16'h0000, 16'h0000, 32'h0000_0000);
		es = 5'h11;
		cst();
		wb(1'b1, OFS_ACC, 32'h8000_0000);
		ex(OPC_TEST64, 16'h0000, 16'h0000, 32'h0000_0000);
		es = 5'h15;
		cst();
		$display("t_64 done");
	endtask

	// A reset in mid-run must clear everything software and compares set.
	task t_rst2();
		wb(1'b1, OFS_REPEAT, 32'h0000_0007);
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		cst_zero();
		chk(32'(cb), 32'h0000_0000);
		chk(32'(rc), 32'h0000_0000);
		rdchk(OFS_ACC, 32'h0000_0000);
		rdchk(OFS_REPEAT, 32'h0000_0000);
		$display("t_rst2 done");
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_cmp();
		t_rpt();
		t_64();
		t_rst2();
		tally_and_finish();
	end
endmodule // tb_compare_flag_unit
